// ==== scsr_top.sv ====
// Overview of operation
// - any soft reset write resets like hardware
// - status read-only; read clears non-freeze bits
// - interrupt when status bit and mask set
// - interrupt level held until cause cleared
// - descriptor handoff sets bit 1 tx, 0 rx
// - empty free ring sets bit 3/2, drops cell
// - free shortage also flags buffer allocation error
// - receive completion ring unavailable sets bit 4
// - tx completion unavailable sets bit 5, freeze
// - transmit freeze halts transmit like disable
// - rx unavailable sets receive freeze, stops receive
// - local bus interrupt sets bit 10
// - one mask bit per status bit
// - config readable: rx en, tx en, filler
// - only clear command clears transmit freeze
// - only clear command clears receive freeze
// - clear command write re-enables that side
// - tx enable resets zero; stops new fetches
// - rx enable resets zero; drops all cells
// - filler: zero unassigned cells, one idle cells
`timescale 1ns/1ps
`include "scsr_regs.svh"

module scsr_top
  import scsr_pkg::*;
(
  // clock and hardware reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  // register access port from the PCI target
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [23:0] i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  output logic [31:0]      o_reg_rdata,
  // datapath events, one-cycle pulses on i_ref_clk
  input  wire logic        i_tx_desc_done,
  input  wire logic        i_rx_desc_done,
  input  wire logic        i_small_free_empty,
  input  wire logic        i_big_free_empty,
  input  wire logic        i_rx_compl_unavail,
  input  wire logic        i_tx_compl_unavail,
  // local bus interrupt pin, asynchronous level
  input  wire logic        i_local_irq,
  // PCI interrupt, open drain active low
  output logic             o_inta_n_out,
  output logic             o_inta_n_oe,
  // datapath controls
  output logic             o_rst_int,
  output logic             o_tx_fetch_en,
  output logic             o_rx_accept_en,
  output logic             o_filler_idle,
  output logic             o_rx_cell_drop,
  output logic             o_alloc_err_set,
  output logic             o_rx_pkt_discard,
  output logic [10:0]      o_rate_table_length,
  output logic [19:0]      o_queue_peak_depth
);

  scsr_evt_if evt ();

  logic       rst_int;
  logic       soft_req;
  logic       wr_status_rd;
  logic       wr_tx_clr;
  logic       wr_rx_clr;

  // write and read strobes per register
  function automatic logic hit(input logic [23:0] addr, input logic [23:0] off);
    hit = (addr == off);
  endfunction : hit

  assign soft_req     = i_reg_wr & hit(i_reg_addr, `SCSR_OFF_SOFT_RESET);
  assign wr_status_rd = i_reg_rd & hit(i_reg_addr, `SCSR_OFF_STATUS);
  assign wr_tx_clr    = i_reg_wr & hit(i_reg_addr, `SCSR_OFF_TX_HALT_CLR);
  assign wr_rx_clr    = i_reg_wr & hit(i_reg_addr, `SCSR_OFF_RX_HALT_CLR);

  // software reset generator, held only by the hardware reset
  scsr_reset_gen u_rst (
    .i_ref_clk  (i_ref_clk),
    .i_rst      (i_rst),
    .i_soft_req (soft_req),
    .o_rst_int  (rst_int)
  );

  assign o_rst_int = rst_int;

  // local interrupt pin synchroniser, three stages
  logic       lirq_s1_q;
  logic       lirq_s2_q;
  logic       lirq_s3_q;
  logic       lirq_lvl_q;
  logic       lirq_lvl_d;
  logic       lirq_rise;

  // accepted level moves only when the second and third stages agree
  always_comb begin
    lirq_lvl_d = lirq_lvl_q;
    if (lirq_s2_q == lirq_s3_q) begin
      lirq_lvl_d = lirq_s3_q;
    end
    lirq_rise = lirq_lvl_d & ~lirq_lvl_q;
  end

  // synchroniser and accepted level registers
  always_ff @(posedge i_ref_clk or posedge rst_int) begin
    if (rst_int) begin
      lirq_s1_q  <= 1'b0;
      lirq_s2_q  <= 1'b0;
      lirq_s3_q  <= 1'b0;
      lirq_lvl_q <= 1'b0;
    end else begin
      lirq_s1_q  <= i_local_irq;
      lirq_s2_q  <= lirq_s1_q;
      lirq_s3_q  <= lirq_s2_q;
      lirq_lvl_q <= lirq_lvl_d;
    end
  end

  // gather datapath events into the status set vector
  always_comb begin
    evt.set_ev = '0;
    evt.set_ev[`SCSR_BIT_RX_DONE]     = i_rx_desc_done;
    evt.set_ev[`SCSR_BIT_TX_DONE]     = i_tx_desc_done;
    evt.set_ev[`SCSR_BIT_SMALL_EMPTY] = i_small_free_empty;
    evt.set_ev[`SCSR_BIT_BIG_EMPTY]   = i_big_free_empty;
    evt.set_ev[`SCSR_BIT_RX_UNAVAIL]  = i_rx_compl_unavail;
    evt.set_ev[`SCSR_BIT_TX_UNAVAIL]  = i_tx_compl_unavail;
    evt.set_ev[`SCSR_BIT_LOCAL_IRQ]   = lirq_rise;
  end

  assign evt.rd_clr     = wr_status_rd;
  assign evt.tx_frz_clr = wr_tx_clr;
  assign evt.rx_frz_clr = wr_rx_clr;

  // sticky event status with clear-on-read
  scsr_status_bank u_stat (
    .i_ref_clk (i_ref_clk),
    .i_rst     (rst_int),
    .evt       (evt)
  );

  // writable registers
  scsr_stat_t                    mask_q;
  scsr_stat_t                    mask_d;
  logic                          tx_en_q;
  logic                          tx_en_d;
  logic                          rx_en_q;
  logic                          rx_en_d;
  logic                          filler_q;
  logic                          filler_d;
  logic [`SCSR_RATE_LEN_W-1:0]   rate_len_q;
  logic [`SCSR_RATE_LEN_W-1:0]   rate_len_d;
  logic [`SCSR_PEAK_DEPTH_W-1:0] peak_q;
  logic [`SCSR_PEAK_DEPTH_W-1:0] peak_d;

  // register write decode
  always_comb begin
    mask_d     = mask_q;
    tx_en_d    = tx_en_q;
    rx_en_d    = rx_en_q;
    filler_d   = filler_q;
    rate_len_d = rate_len_q;
    peak_d     = peak_q;
    if (i_reg_wr) begin
      if (hit(i_reg_addr, `SCSR_OFF_MASK)) begin
        mask_d = i_reg_wdata[`SCSR_STAT_W-1:0] & scsr_stat_t'(`SCSR_STAT_IMPL);
      end else if (hit(i_reg_addr, `SCSR_OFF_CONFIG)) begin
        tx_en_d  = i_reg_wdata[`SCSR_BIT_TX_EN];
        rx_en_d  = i_reg_wdata[`SCSR_BIT_RX_EN];
        filler_d = i_reg_wdata[`SCSR_BIT_FILLER];
      end else if (hit(i_reg_addr, `SCSR_OFF_RATE_LEN)) begin
        rate_len_d = i_reg_wdata[`SCSR_RATE_LEN_W-1:0];
      end else if (hit(i_reg_addr, `SCSR_OFF_PEAK_DEPTH)) begin
        peak_d = i_reg_wdata[`SCSR_PEAK_DEPTH_W-1:0];
      end
    end
  end

  // enables reset to zero, so both sides start disabled
  always_ff @(posedge i_ref_clk or posedge rst_int) begin
    if (rst_int) begin
      mask_q     <= `SCSR_STAT_RESET;
      tx_en_q    <= `SCSR_CFG_RESET;
      rx_en_q    <= `SCSR_CFG_RESET;
      filler_q   <= `SCSR_CFG_RESET;
      rate_len_q <= '0;
      peak_q     <= '0;
    end else begin
      mask_q     <= mask_d;
      tx_en_q    <= tx_en_d;
      rx_en_q    <= rx_en_d;
      filler_q   <= filler_d;
      rate_len_q <= rate_len_d;
      peak_q     <= peak_d;
    end
  end

  // read data mux; write-only, reserved and unmapped words read zero
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  always_comb begin
    rdata_d = rdata_q;
    if (i_reg_rd) begin
      rdata_d = `SCSR_DATA_RESET;
      if (hit(i_reg_addr, `SCSR_OFF_STATUS)) begin
        rdata_d[`SCSR_STAT_W-1:0] = evt.status;
      end else if (hit(i_reg_addr, `SCSR_OFF_MASK)) begin
        rdata_d[`SCSR_STAT_W-1:0] = mask_q;
      end else if (hit(i_reg_addr, `SCSR_OFF_CONFIG)) begin
        rdata_d[`SCSR_BIT_TX_EN]  = tx_en_q;
        rdata_d[`SCSR_BIT_RX_EN]  = rx_en_q;
        rdata_d[`SCSR_BIT_FILLER] = filler_q;
      end else if (hit(i_reg_addr, `SCSR_OFF_RATE_LEN)) begin
        rdata_d[`SCSR_RATE_LEN_W-1:0] = rate_len_q;
      end else if (hit(i_reg_addr, `SCSR_OFF_PEAK_DEPTH)) begin
        rdata_d[`SCSR_PEAK_DEPTH_W-1:0] = peak_q;
      end
    end
  end

  // datapath side pulses
  logic rx_drop_q;
  logic rx_drop_d;
  logic alloc_q;
  logic alloc_d;
  logic discard_q;
  logic discard_d;

  // cell drop and allocation error on either free ring shortage
  always_comb begin
    alloc_d   = i_small_free_empty | i_big_free_empty;
    rx_drop_d = alloc_d;
    discard_d = i_rx_compl_unavail;
  end

  // read data and pulse registers
  always_ff @(posedge i_ref_clk or posedge rst_int) begin
    if (rst_int) begin
      rdata_q   <= `SCSR_DATA_RESET;
      rx_drop_q <= 1'b0;
      alloc_q   <= 1'b0;
      discard_q <= 1'b0;
    end else begin
      rdata_q   <= rdata_d;
      rx_drop_q <= rx_drop_d;
      alloc_q   <= alloc_d;
      discard_q <= discard_d;
    end
  end

  // interrupt follows status and mask, no edge needed to release it
  logic irq_any;

  assign irq_any      = |(evt.status & mask_q);
  assign o_inta_n_out = 1'b0;
  assign o_inta_n_oe  = irq_any;

  // freezes act exactly like clearing the matching enable
  assign o_tx_fetch_en  = tx_en_q & ~evt.status[`SCSR_BIT_TX_FREEZE];
  assign o_rx_accept_en = rx_en_q & ~evt.status[`SCSR_BIT_RX_FREEZE];
  assign o_filler_idle  = filler_q;

  assign o_reg_rdata         = rdata_q;
  assign o_rx_cell_drop      = rx_drop_q;
  assign o_alloc_err_set     = alloc_q;
  assign o_rx_pkt_discard    = discard_q;
  assign o_rate_table_length = rate_len_q;
  assign o_queue_peak_depth  = peak_q;

endmodule : scsr_top

// ==== scsr_regs.svh ====
`ifndef SCSR_REGS_SVH
`define SCSR_REGS_SVH

// register byte offsets inside the device memory window
`define SCSR_ADDR_W           24
`define SCSR_OFF_SOFT_RESET   24'h00E000
`define SCSR_OFF_STATUS       24'h00E004
`define SCSR_OFF_MASK         24'h00E008
`define SCSR_OFF_CONFIG       24'h00E00C
`define SCSR_OFF_RSVD_A       24'h00E010
`define SCSR_OFF_RATE_LEN     24'h00E014
`define SCSR_OFF_PEAK_DEPTH   24'h00E018
`define SCSR_OFF_RSVD_B       24'h00E01C
`define SCSR_OFF_TX_HALT_CLR  24'h00E020
`define SCSR_OFF_RX_HALT_CLR  24'h00E024

// event status field positions
`define SCSR_STAT_W           12
`define SCSR_BIT_RX_DONE      0
`define SCSR_BIT_TX_DONE      1
`define SCSR_BIT_SMALL_EMPTY  2
`define SCSR_BIT_BIG_EMPTY    3
`define SCSR_BIT_RX_UNAVAIL   4
`define SCSR_BIT_TX_UNAVAIL   5
`define SCSR_BIT_TX_FREEZE    6
`define SCSR_BIT_RX_FREEZE    7
`define SCSR_BIT_LOCAL_IRQ    10
`define SCSR_STAT_IMPL        12'h4FF
`define SCSR_STAT_KEEP        12'h0C0
`define SCSR_STAT_RESET       12'h000

// engine configuration field positions
`define SCSR_BIT_TX_EN        1
`define SCSR_BIT_RX_EN        2
`define SCSR_BIT_FILLER       5
`define SCSR_CFG_RESET        1'b0

// other register widths and reset values
`define SCSR_RATE_LEN_W       11
`define SCSR_PEAK_DEPTH_W     20
`define SCSR_DATA_RESET       32'h0000_0000

// internal reset hold length after a software reset write, in cycles
`define SCSR_SRST_CYCLES      4'h8

`endif

// ==== scsr_pkg.sv ====
package scsr_pkg;

  // status and mask vector
  typedef logic [11:0] scsr_stat_t;

  // reset generator states
  typedef enum logic [1:0] {
    SCSR_RUN  = 2'b00,
    SCSR_HOLD = 2'b01
  } scsr_rst_state_e;

endpackage : scsr_pkg

// ==== scsr_evt_if.sv ====
`timescale 1ns/1ps

// carries events and clear commands between the top and the status bank
interface scsr_evt_if;
  import scsr_pkg::*;

  scsr_stat_t set_ev;      // one-cycle event pulses, one per status bit
  logic       rd_clr;      // status register read this cycle
  logic       tx_frz_clr;  // clear transmit freeze command
  logic       rx_frz_clr;  // clear receive freeze command
  scsr_stat_t status;      // current status bits

  modport ctrl (
    output set_ev,
    output rd_clr,
    output tx_frz_clr,
    output rx_frz_clr,
    input  status
  );

  modport bank (
    input  set_ev,
    input  rd_clr,
    input  tx_frz_clr,
    input  rx_frz_clr,
    output status
  );

endinterface : scsr_evt_if

// ==== scsr_status_bank.sv ====
`timescale 1ns/1ps
`include "scsr_regs.svh"

module scsr_status_bank
  import scsr_pkg::*;
(
  // clock and reset
  input  wire logic  i_ref_clk,
  input  wire logic  i_rst,
  // event and clear channel
  scsr_evt_if.bank   evt
);

  scsr_stat_t stat_q;
  scsr_stat_t stat_d;
  scsr_stat_t set_v;
  scsr_stat_t clr_v;

  // next status: set always wins over any clear in the same cycle
  always_comb begin
    set_v = evt.set_ev;
    set_v[`SCSR_BIT_TX_FREEZE] = evt.set_ev[`SCSR_BIT_TX_UNAVAIL];
    set_v[`SCSR_BIT_RX_FREEZE] = evt.set_ev[`SCSR_BIT_RX_UNAVAIL];
    clr_v = evt.rd_clr ? ~scsr_stat_t'(`SCSR_STAT_KEEP) : '0;
    clr_v[`SCSR_BIT_TX_FREEZE] = evt.tx_frz_clr;
    clr_v[`SCSR_BIT_RX_FREEZE] = evt.rx_frz_clr;
    stat_d = ((stat_q & ~clr_v) | set_v) & scsr_stat_t'(`SCSR_STAT_IMPL);
  end

  // status storage
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      stat_q <= `SCSR_STAT_RESET;
    end else begin
      stat_q <= stat_d;
    end
  end

  assign evt.status = stat_q;

endmodule : scsr_status_bank

// ==== scsr_reset_gen.sv ====
`timescale 1ns/1ps
`include "scsr_regs.svh"

module scsr_reset_gen
  import scsr_pkg::*;
(
  // clock and hardware reset
  input  wire logic  i_ref_clk,
  input  wire logic  i_rst,
  // software reset request pulse
  input  wire logic  i_soft_req,
  // internal reset for the whole engine
  output logic       o_rst_int
);

  scsr_rst_state_e state_q;
  scsr_rst_state_e state_d;
  logic [3:0]      cnt_q;
  logic [3:0]      cnt_d;
  logic            rst_q;
  logic            rst_d;

  // hold the engine in reset for a fixed count after a soft request
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      SCSR_RUN: begin
        if (i_soft_req) begin
          state_d = SCSR_HOLD;
          cnt_d   = `SCSR_SRST_CYCLES;
        end
      end
      SCSR_HOLD: begin
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h1) begin
          state_d = SCSR_RUN;
        end
      end
      default: state_d = SCSR_RUN;
    endcase
    rst_d = (state_d == SCSR_HOLD);
  end

  // registered so the internal reset is glitch free
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= SCSR_RUN;
      cnt_q   <= 4'h0;
      rst_q   <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      rst_q   <= rst_d;
    end
  end

  assign o_rst_int = rst_q;

endmodule : scsr_reset_gen

// ==== scsr_props.sv ====
`timescale 1ns/1ps
`include "scsr_regs.svh"

module scsr_props (
  // clock and reset
  input wire logic        i_ref_clk,
  input wire logic        i_rst,
  // register port
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [23:0] i_reg_addr,
  input wire logic [31:0] o_reg_rdata,
  // datapath events
  input wire logic        i_small_free_empty,
  input wire logic        i_big_free_empty,
  input wire logic        i_rx_compl_unavail,
  input wire logic        i_tx_compl_unavail,
  // watched outputs
  input wire logic        o_inta_n_oe,
  input wire logic        o_rst_int,
  input wire logic        o_tx_fetch_en,
  input wire logic        o_rx_accept_en,
  input wire logic        o_rx_cell_drop,
  input wire logic        o_alloc_err_set,
  input wire logic        o_rx_pkt_discard
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  // soft reset write holds the internal reset for eight cycles
  property p_srst;
    i_reg_wr && i_reg_addr == `SCSR_OFF_SOFT_RESET && !o_rst_int |=> o_rst_int [*8];
  endproperty
  a_srst: assert property (p_srst) else $error("soft reset hold too short");

  // transmit completion shortage stops fetching next cycle
  property p_tx_frz;
    i_tx_compl_unavail && !o_rst_int |=> !o_tx_fetch_en;
  endproperty
  a_tx_frz: assert property (p_tx_frz) else $error("tx fetch not halted");

  // receive completion shortage stops receive and discards the packet
  property p_rx_frz;
    i_rx_compl_unavail && !o_rst_int |=> !o_rx_accept_en && o_rx_pkt_discard;
  endproperty
  a_rx_frz: assert property (p_rx_frz) else $error("rx not frozen or packet kept");

  // free ring shortage drops the cell and flags an allocation error
  property p_drop;
    (i_small_free_empty || i_big_free_empty) && !o_rst_int |=> o_rx_cell_drop && o_alloc_err_set;
  endproperty
  a_drop: assert property (p_drop) else $error("free shortage not signalled");

  // transmit resumes only after a clear command or a config write
  property p_tx_clr;
    $rose(o_tx_fetch_en) |-> $past(i_reg_wr) &&
      ($past(i_reg_addr) == `SCSR_OFF_TX_HALT_CLR || $past(i_reg_addr) == `SCSR_OFF_CONFIG);
  endproperty
  a_tx_clr: assert property (p_tx_clr) else $error("tx resumed without host write");

  // receive resumes only after a clear command or a config write
  property p_rx_clr;
    $rose(o_rx_accept_en) |-> $past(i_reg_wr) &&
      ($past(i_reg_addr) == `SCSR_OFF_RX_HALT_CLR || $past(i_reg_addr) == `SCSR_OFF_CONFIG);
  endproperty
  a_rx_clr: assert property (p_rx_clr) else $error("rx resumed without host write");

  // interrupt drops only after a host access or internal reset
  property p_irq_hold;
    $fell(o_inta_n_oe) |-> $past(i_reg_rd) || $past(i_reg_wr) || $past(o_rst_int);
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped on its own");

  // read data holds between reads
  property p_rd_hold;
    !$past(i_reg_rd) && !o_rst_int && !$past(o_rst_int) |-> $stable(o_reg_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data changed without read");

  // main scenarios reached
  c_tx_frz: cover property (i_tx_compl_unavail ##1 !o_tx_fetch_en);
  c_irq: cover property ($rose(o_inta_n_oe));
  c_srst: cover property ($rose(o_rst_int));
endmodule : scsr_props

bind scsr_top scsr_props i_scsr_props (.i_ref_clk, .i_rst, .i_reg_wr, .i_reg_rd, .i_reg_addr, .o_reg_rdata,
  .i_small_free_empty, .i_big_free_empty, .i_rx_compl_unavail, .i_tx_compl_unavail, .o_inta_n_oe,
  .o_rst_int, .o_tx_fetch_en, .o_rx_accept_en, .o_rx_cell_drop, .o_alloc_err_set, .o_rx_pkt_discard);

// ==== scsr_host_model.sv ====
`timescale 1ns/1ps
`include "scsr_regs.svh"

module scsr_host_model (
  // clock and read data
  input  wire logic        i_ref_clk,
  input  wire logic [31:0] i_rdata,
  // register strobes
  output logic             o_wr,
  output logic             o_rd,
  output logic [23:0]      o_addr,
  output logic [31:0]      o_wdata
);
  logic [31:0] pci_cmd;
  int          lost_bufs;

  // idle bus at time zero
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 24'h000000;
    o_wdata = 32'h0000_0000;
    pci_cmd = 32'h0000_0006;
    lost_bufs = 0;
  end

  // one write cycle, then the lines stop showing old values
  task automatic wr(input logic [23:0] a, input logic [31:0] d);
    @(negedge i_ref_clk);
    o_wr = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(negedge i_ref_clk);
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask : wr

  // one read cycle, data taken after the sampling edge
  task automatic rd(input logic [23:0] a, output logic [31:0] d);
    @(negedge i_ref_clk);
    o_rd = 1'b1;
    o_addr = a;
    @(negedge i_ref_clk);
    o_rd = 1'b0;
    o_addr = ~a;
    d = i_rdata;
  endtask : rd

  // save command word, reset, wait, restore it
  task automatic soft_reset(input logic [31:0] d);
    logic [31:0] saved;
    saved = pci_cmd;
    wr(`SCSR_OFF_SOFT_RESET, d);
    repeat (10) @(negedge i_ref_clk);
    pci_cmd = saved;
  endtask : soft_reset

  // software takes back the unposted buffer, then unfreezes receive
  task automatic recover_rx();
    lost_bufs++;
    wr(`SCSR_OFF_RX_HALT_CLR, 32'h0000_0000);
  endtask : recover_rx
endmodule : scsr_host_model

// ==== tb_top.sv ====
`timescale 1ns/1ps
`include "scsr_regs.svh"
`define CHK(n, e, g) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, g); \
  end \
end

module tb_top;
  import scsr_pkg::*;
  logic        clk;
  logic        rst;
  logic        wr;
  logic        rd;
  logic [23:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [5:0]  ev;
  logic        lirq;
  logic        oe;
  logic        fetch;
  logic        accept;
  logic        filler;
  logic        rst_int;
  logic        inta_out;
  logic        drop;
  logic        alloc;
  logic        discard;
  logic [10:0] rate;
  logic [19:0] peak;
  logic [31:0] d;
  logic [31:0] r;
  logic [31:0] seed = 32'd55378;
  int          fail_count = 0;
  int          checks_done = 0;
  int          cyc = 0;
  logic [23:0] addrs [10] = '{`SCSR_OFF_SOFT_RESET, `SCSR_OFF_STATUS, `SCSR_OFF_MASK, `SCSR_OFF_CONFIG,
    `SCSR_OFF_RSVD_A, `SCSR_OFF_RATE_LEN, `SCSR_OFF_PEAK_DEPTH, `SCSR_OFF_RSVD_B, `SCSR_OFF_TX_HALT_CLR,
    `SCSR_OFF_RX_HALT_CLR};

  scsr_top i_scsr_top (.i_ref_clk(clk), .i_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_tx_desc_done(ev[1]), .i_rx_desc_done(ev[0]),
    .i_small_free_empty(ev[2]), .i_big_free_empty(ev[3]), .i_rx_compl_unavail(ev[4]),
    .i_tx_compl_unavail(ev[5]), .i_local_irq(lirq), .o_inta_n_out(inta_out), .o_inta_n_oe(oe),
    .o_rst_int(rst_int), .o_tx_fetch_en(fetch), .o_rx_accept_en(accept), .o_filler_idle(filler),
    .o_rx_cell_drop(drop), .o_alloc_err_set(alloc), .o_rx_pkt_discard(discard),
    .o_rate_table_length(rate), .o_queue_peak_depth(peak));

  scsr_host_model i_host (.i_ref_clk(clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_addr(addr),
    .o_wdata(wdata));

  // xorshift source for register data
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // status after one event: its bit plus any freeze it causes
  function automatic logic [31:0] exp_stat(input int b);
    return (32'h1 << b) | ((b == 5) ? 32'h40 : 32'h0) | ((b == 4) ? 32'h80 : 32'h0);
  endfunction : exp_stat

  // one-cycle datapath event pulse
  task automatic pulse(input int b);
    @(negedge clk);
    ev[b] = 1'b1;
    @(negedge clk);
    ev = 6'h00;
  endtask : pulse

  // verdict and end of run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  // clock generator
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      end_sim();
    end
  end

  // test sequence
  initial begin
    rst = 1'b1;
    ev = 6'h00;
    lirq = 1'b0;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    foreach (addrs[k]) begin
      i_host.rd(addrs[k], r);
      `CHK("reset value", 32'h0, r)
    end
    `CHK("tx enable", 1'b0, fetch)
    `CHK("rx enable", 1'b0, accept)
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      d = xs();
      i_host.wr(`SCSR_OFF_MASK, d);
      i_host.rd(`SCSR_OFF_MASK, r);
      `CHK("mask", d & 32'h4FF, r)
      i_host.wr(`SCSR_OFF_CONFIG, d);
      i_host.rd(`SCSR_OFF_CONFIG, r);
      `CHK("config", d & 32'h26, r)
      `CHK("filler", d[5], filler)
      `CHK("tx fetch", d[1], fetch)
      `CHK("rx accept", d[2], accept)
      i_host.wr(`SCSR_OFF_RATE_LEN, d);
      i_host.wr(`SCSR_OFF_PEAK_DEPTH, d);
      `CHK("rate out", d[10:0], rate)
      `CHK("peak out", d[19:0], peak)
      i_host.wr(`SCSR_OFF_STATUS, d);
      i_host.wr(`SCSR_OFF_RSVD_A, d);
      i_host.rd(`SCSR_OFF_STATUS, r);
      `CHK("status write", 32'h0, r)
      i_host.rd(`SCSR_OFF_RSVD_A, r);
      `CHK("reserved", 32'h0, r)
    end
    $display("test registers done");
    i_host.wr(`SCSR_OFF_CONFIG, 32'h0000_0006);
    i_host.wr(`SCSR_OFF_MASK, 32'h0000_04FE);
    pulse(0);
    @(negedge clk);
    `CHK("masked irq", 1'b0, oe)
    i_host.rd(`SCSR_OFF_STATUS, r);
    `CHK("masked status", 32'h1, r)
    for (int b = 0; b < 6; b++) begin
      i_host.wr(`SCSR_OFF_MASK, 32'hC0 | (32'h1 << b));
      pulse(b);
      `CHK("cell drop", (b == 2 || b == 3), drop)
      `CHK("alloc error", (b == 2 || b == 3), alloc)
      `CHK("packet discard", (b == 4), discard)
      @(negedge clk);
      `CHK("drop pulse end", 1'b0, drop)
      `CHK("irq", 1'b1, oe)
      `CHK("irq pin low", 1'b0, inta_out)
      `CHK("tx halted", (b != 5), fetch)
      `CHK("rx halted", (b != 4), accept)
      i_host.rd(`SCSR_OFF_STATUS, r);
      `CHK("status", exp_stat(b), r)
      i_host.rd(`SCSR_OFF_STATUS, r);
      `CHK("kept", exp_stat(b) & 32'hC0, r)
      `CHK("irq held", (b >= 4), oe)
      i_host.wr(`SCSR_OFF_TX_HALT_CLR, xs());
      i_host.recover_rx();
      i_host.rd(`SCSR_OFF_STATUS, r);
      `CHK("cleared", 32'h0, r)
      `CHK("resumed", 2'b11, {fetch, accept})
      `CHK("irq gone", 1'b0, oe)
    end
    i_host.wr(`SCSR_OFF_MASK, 32'h0000_0400);
    @(negedge clk);
    lirq = 1'b1;
    repeat (6) @(negedge clk);
    lirq = 1'b0;
    `CHK("local irq", 1'b1, oe)
    i_host.rd(`SCSR_OFF_STATUS, r);
    `CHK("local status", 32'h400, r)
    $display("test events done");
    fork
      i_host.rd(`SCSR_OFF_STATUS, r);
      pulse(0);
    join
    i_host.rd(`SCSR_OFF_STATUS, r);
    `CHK("event at read", 32'h1, r)
    $display("test read race done");
    i_host.wr(`SCSR_OFF_MASK, 32'h0000_04FF);
    i_host.soft_reset(xs());
    i_host.rd(`SCSR_OFF_CONFIG, r);
    `CHK("config after srst", 32'h0, r)
    i_host.rd(`SCSR_OFF_MASK, r);
    `CHK("mask after srst", 32'h0, r)
    `CHK("internal reset", 1'b0, rst_int)
    $display("test soft reset done");
    end_sim();
  end
endmodule : tb_top
